// ===== bit_manip_pkg.sv
/*
 Package for the bit-manipulation unit: operation codes, operand and
 result carriers, and reset values.
 Assumes a single core clock domain; used with package-qualified names.
*/
package bit_manip_pkg;

   localparam int BYTE_W = 8;
   localparam int INDEX_W = 3;

   // One-hot state codes for the unit's result stage
   localparam logic [1:0] STATE_IDLE_CODE = 2'h1;
   localparam logic [1:0] STATE_DONE_CODE = 2'h2;

   // Values after reset
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic RESET_FLAG = 1'h0;

   // Latency from request to result, in core clock cycles
   localparam int RESULT_LATENCY = 1;

   typedef enum logic [3:0] {
      set_bit_op = 4'h0,
      clear_bit_op = 4'h1,
      invert_bit_op = 4'h2,
      test_bit_op = 4'h3,
      carry_and_bit_op = 4'h4,
      carry_and_inv_bit_op = 4'h5,
      carry_or_bit_op = 4'h6,
      carry_or_inv_bit_op = 4'h7,
      carry_xor_bit_op = 4'h8,
      carry_xor_inv_bit_op = 4'h9,
      load_bit_to_carry_op = 4'hA,
      load_inv_bit_to_carry_op = 4'hB,
      store_carry_to_bit_op = 4'hC,
      store_inv_carry_to_bit_op = 4'hD
   } bit_op_t;

   typedef struct packed {
      logic valid;
      bit_op_t op;
      logic [7:0] operand;
      logic [2:0] imm_index;
      logic index_from_reg;
      logic [7:0] index_reg;
      logic carry_in;
      logic zero_in;
   } bit_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] operand;
      logic write_operand;
      logic carry;
      logic zero;
      logic bad_index_source;
   } bit_result_t;

endpackage : bit_manip_pkg

// ===== bit_manipulation_unit.sv
/*
 Bit-manipulation datapath of an 8-bit core: set, clear, invert, test,
 carry logic with a selected bit, and carry-to-bit copies.
 Assumes the sequencer presents one request per cycle with the current
 carry and zero flags, and writes back the result it gets one cycle later.
*/
// Notes on behaviour
// RULE_01: Set writes one into the selected bit
// RULE_02: Clear writes zero into the selected bit
// RULE_03: Invert complements only the selected bit
// RULE_04: Test loads zero flag with inverted bit
// RULE_05: Index from immediate or register low bits
// RULE_06: Carry becomes carry AND selected bit
// RULE_07: Carry becomes carry AND inverted bit
// RULE_08: Carry becomes carry OR selected bit
// RULE_09: Carry becomes carry OR inverted bit
// RULE_10: Carry becomes carry XOR selected bit
// RULE_11: Carry becomes carry XOR inverted bit
// RULE_12: Carry loaded with the selected bit
// RULE_13: Carry loaded with the inverted bit
// RULE_14: Carry written into the selected bit
// RULE_15: Inverted carry written into selected bit
// RULE_16: Inverted variants use immediate index only
// RULE_17: Byte operand; other flags stay unchanged
module bit_manipulation_unit
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Request from the sequencer
   input wire bit_manip_pkg::bit_req_t req,
   // Result to the register file and flags
   output bit_manip_pkg::bit_result_t result
);

   // ==========================================================
   // Index and bit selection
   // ==========================================================
   logic [2:0] index;
   logic [7:0] mask;
   logic picked;
   logic inv_variant;
   logic bad_source;

   assign inv_variant = (req.op == bit_manip_pkg::carry_and_inv_bit_op)
      || (req.op == bit_manip_pkg::carry_or_inv_bit_op)
      || (req.op == bit_manip_pkg::carry_xor_inv_bit_op)
      || (req.op == bit_manip_pkg::load_inv_bit_to_carry_op)
      || (req.op == bit_manip_pkg::store_inv_carry_to_bit_op);

   // A register index for an inverted variant has no encoding; it is
   // refused rather than silently retargeted
   assign bad_source = inv_variant && req.index_from_reg; // RULE_16

   bit_select bit_select_inst
   (
      .imm_index(req.imm_index),
      .index_from_reg(req.index_from_reg),
      .index_reg(req.index_reg),
      .operand(req.operand),
      .index(index),
      .mask(mask),
      .picked(picked)
   );

   // ==========================================================
   // Operation decode
   // ==========================================================
   function automatic logic [7:0] put_bit(input logic [7:0] val,
                                          input logic [7:0] m,
                                          input logic b);
      put_bit = b ? (val | m) : (val & ~m);
   endfunction : put_bit

   logic [7:0] next_operand;
   logic next_write;
   logic next_carry;
   logic next_zero;

   always_comb
   begin
      // Flags not named by the operation pass through untouched
      next_operand = req.operand; // RULE_17
      next_write = 1'b0;
      next_carry = req.carry_in;
      next_zero = req.zero_in;
      case (req.op)
         bit_manip_pkg::set_bit_op:
         begin
            next_operand = put_bit(req.operand, mask, 1'b1); // RULE_01
            next_write = 1'b1;
         end
         bit_manip_pkg::clear_bit_op:
         begin
            next_operand = put_bit(req.operand, mask, 1'b0); // RULE_02
            next_write = 1'b1;
         end
         bit_manip_pkg::invert_bit_op:
         begin
            next_operand = req.operand ^ mask; // RULE_03
            next_write = 1'b1;
         end
         bit_manip_pkg::test_bit_op:
            next_zero = ~picked; // RULE_04
         bit_manip_pkg::carry_and_bit_op:
            next_carry = req.carry_in & picked; // RULE_06
         bit_manip_pkg::carry_and_inv_bit_op:
            next_carry = req.carry_in & ~picked; // RULE_07
         bit_manip_pkg::carry_or_bit_op:
            next_carry = req.carry_in | picked; // RULE_08
         bit_manip_pkg::carry_or_inv_bit_op:
            next_carry = req.carry_in | ~picked; // RULE_09
         bit_manip_pkg::carry_xor_bit_op:
            next_carry = req.carry_in ^ picked; // RULE_10
         bit_manip_pkg::carry_xor_inv_bit_op:
            next_carry = req.carry_in ^ ~picked; // RULE_11
         bit_manip_pkg::load_bit_to_carry_op:
            next_carry = picked; // RULE_12
         bit_manip_pkg::load_inv_bit_to_carry_op:
            next_carry = ~picked; // RULE_13
         bit_manip_pkg::store_carry_to_bit_op:
         begin
            next_operand = put_bit(req.operand, mask, req.carry_in); // RULE_14
            next_write = 1'b1;
         end
         bit_manip_pkg::store_inv_carry_to_bit_op:
         begin
            next_operand = put_bit(req.operand, mask, ~req.carry_in); // RULE_15
            next_write = 1'b1;
         end
         default:
         begin
            next_operand = req.operand;
            next_write = 1'b0;
         end
      endcase
      // A refused request changes nothing
      if (bad_source)
      begin
         next_operand = req.operand;
         next_write = 1'b0;
         next_carry = req.carry_in;
         next_zero = req.zero_in;
      end
   end

   // ==========================================================
   // Result stage
   // ==========================================================
   typedef enum logic [1:0] {
      st_idle = bit_manip_pkg::STATE_IDLE_CODE,
      st_done = bit_manip_pkg::STATE_DONE_CODE
   } stage_state_t;

   stage_state_t state;
   stage_state_t next_state;

   always_comb
   begin
      case (state)
         st_idle: next_state = req.valid ? st_done : st_idle;
         st_done: next_state = req.valid ? st_done : st_idle;
         default: next_state = st_idle;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= st_idle;
         result.valid <= 1'b0;
         result.operand <= bit_manip_pkg::RESULT_RESET;
         result.write_operand <= 1'b0;
         result.carry <= bit_manip_pkg::RESET_FLAG;
         result.zero <= bit_manip_pkg::RESET_FLAG;
         result.bad_index_source <= 1'b0;
      end
      else
      begin
         state <= next_state;
         result.valid <= req.valid;
         result.operand <= next_operand;
         result.write_operand <= req.valid && next_write;
         result.carry <= next_carry;
         result.zero <= next_zero;
         result.bad_index_source <= req.valid && bad_source;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   set_writes_one_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_01
      (req.valid && req.op == bit_manip_pkg::set_bit_op && !bad_source)
      |=> (result.operand == ($past(req.operand) | $past(mask))) && result.write_operand)
      else $error("set did not write one");

   clear_writes_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_02
      (req.valid && req.op == bit_manip_pkg::clear_bit_op)
      |=> result.operand == ($past(req.operand) & ~$past(mask)))
      else $error("clear did not write zero");

   invert_one_bit_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_03
      (req.valid && req.op == bit_manip_pkg::invert_bit_op)
      |=> $countones(result.operand ^ $past(req.operand)) == 1)
      else $error("invert changed wrong bits");

   invert_right_bit_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_03
      (req.valid && req.op == bit_manip_pkg::invert_bit_op)
      |=> result.operand == ($past(req.operand) ^ $past(mask)))
      else $error("invert hit the wrong bit");

   test_keeps_byte_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_04
      (req.valid && req.op == bit_manip_pkg::test_bit_op)
      |=> result.operand == $past(req.operand))
      else $error("test altered the operand");

   test_zero_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_04
      (req.valid && req.op == bit_manip_pkg::test_bit_op)
      |=> (result.zero == !$past(picked)) && !result.write_operand)
      else $error("test set zero wrongly");

   reg_index_low_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_05
      req.index_from_reg |-> index == req.index_reg[2:0])
      else $error("register index not used");

   carry_and_inv_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_07
      (req.valid && req.op == bit_manip_pkg::carry_and_inv_bit_op && !req.index_from_reg)
      |=> result.carry == ($past(req.carry_in) && !$past(picked)))
      else $error("inverted and carry wrong");

   carry_and_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_06
      (req.valid && req.op == bit_manip_pkg::carry_and_bit_op)
      |=> result.carry == ($past(req.carry_in) && $past(picked)))
      else $error("and carry wrong");

   carry_or_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_08
      (req.valid && req.op == bit_manip_pkg::carry_or_bit_op)
      |=> result.carry == ($past(req.carry_in) || $past(picked)))
      else $error("or carry wrong");

   carry_or_inv_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_09
      (req.valid && req.op == bit_manip_pkg::carry_or_inv_bit_op && !req.index_from_reg)
      |=> result.carry == ($past(req.carry_in) || !$past(picked)))
      else $error("inverted or carry wrong");

   carry_xor_inv_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_11
      (req.valid && req.op == bit_manip_pkg::carry_xor_inv_bit_op && !req.index_from_reg)
      |=> result.carry == ($past(req.carry_in) ^ !$past(picked)))
      else $error("inverted xor carry wrong");

   load_carry_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_12
      (req.valid && req.op == bit_manip_pkg::load_bit_to_carry_op)
      |=> (result.carry == $past(picked)) && !result.write_operand)
      else $error("load carry wrong");

   load_inv_carry_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_13
      (req.valid && req.op == bit_manip_pkg::load_inv_bit_to_carry_op && !req.index_from_reg)
      |=> (result.carry == !$past(picked)) && !result.write_operand)
      else $error("inverted load carry wrong");

   carry_xor_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_10
      (req.valid && req.op == bit_manip_pkg::carry_xor_bit_op)
      |=> result.carry == ($past(req.carry_in) ^ $past(picked)))
      else $error("xor carry wrong");

   store_carry_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_14
      (req.valid && req.op == bit_manip_pkg::store_carry_to_bit_op)
      |=> result.operand[$past(index)] == $past(req.carry_in))
      else $error("carry not stored");

   store_keeps_rest_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_14
      (req.valid && (req.op == bit_manip_pkg::store_carry_to_bit_op
         || req.op == bit_manip_pkg::store_inv_carry_to_bit_op))
      |=> ((result.operand ^ $past(req.operand)) & ~$past(mask)) == 8'h00)
      else $error("store disturbed other bits");

   store_inv_carry_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_15
      (req.valid && req.op == bit_manip_pkg::store_inv_carry_to_bit_op && !req.index_from_reg)
      |=> (result.operand[$past(index)] == !$past(req.carry_in)) && result.write_operand)
      else $error("inverted carry not stored");

   inv_reg_refused_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_16
      (req.valid && inv_variant && req.index_from_reg)
      |=> result.bad_index_source && !result.write_operand)
      else $error("register index accepted");

   refused_flags_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_16
      (req.valid && bad_source)
      |=> (result.operand == $past(req.operand)) && (result.carry == $past(req.carry_in))
         && (result.zero == $past(req.zero_in)))
      else $error("refused request changed state");

   flags_kept_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_17
      (req.valid && req.op != bit_manip_pkg::test_bit_op)
      |=> result.zero == $past(req.zero_in))
      else $error("zero flag disturbed");

   carry_kept_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_17
      (req.valid && req.op inside {bit_manip_pkg::set_bit_op, bit_manip_pkg::clear_bit_op,
         bit_manip_pkg::invert_bit_op, bit_manip_pkg::test_bit_op})
      |=> result.carry == $past(req.carry_in))
      else $error("carry flag disturbed");

   result_valid_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_17
      req.valid |=> result.valid && (state == st_done))
      else $error("result not returned");

   result_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_17
      !req.valid |=> !result.valid && !result.write_operand && (state == st_idle))
      else $error("result without request");

endmodule : bit_manipulation_unit

// ===== bit_select.sv
/*
 Bit selector: picks the bit index and returns the selected operand bit
 together with a one-hot mask of its position.
 Assumes the index sources are stable in the cycle they are presented.
*/
module bit_select
(
   // Index sources
   input wire logic [2:0] imm_index,
   input wire logic index_from_reg,
   input wire logic [7:0] index_reg,
   // Operand
   input wire logic [7:0] operand,
   // Selection
   output logic [2:0] index,
   output logic [7:0] mask,
   output logic picked
);

   // Only the low three bits of the register matter; upper bits are ignored
   assign index = index_from_reg ? index_reg[2:0] : imm_index; // RULE_05
   assign mask = 8'h01 << index;
   assign picked = operand[index];

endmodule : bit_select

// ===== flag_file_model.sv
/*
 Register-file and flag model behind the unit: one byte plus the C and Z
 flags; C and Z are written back from every result, the byte only with write_operand.
 Assumes the bench drives the preset inputs at the falling clock edge.
*/
module flag_file_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Result from the unit
   input wire bit_manip_pkg::bit_result_t result,
   // Preset from the bench
   input wire logic load,
   input wire logic [7:0] load_byte,
   input wire logic load_c,
   input wire logic load_z,
   // Current state
   output logic [7:0] byte_q,
   output logic carry,
   output logic zero
);
   timeunit 1ns;
   timeprecision 1ps;

   // A preset wins over write-back; the bench never issues both together
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         byte_q <= 8'h00;
         carry <= 1'b0;
         zero <= 1'b0;
      end
      else if (load)
      begin
         byte_q <= load_byte;
         carry <= load_c;
         zero <= load_z;
      end
      else if (result.valid)
      begin
         if (result.write_operand)
            byte_q <= result.operand;
         carry <= result.carry;
         zero <= result.zero;
      end
   end
endmodule : flag_file_model

// ===== tb_bit_manipulation_unit.sv
/*
 Self-checking bench for the bit-manipulation unit with a flag file model.
 Assumes a 50 MHz core clock and one request at a time.
*/
module tb_bit_manipulation_unit;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   bit_manip_pkg::bit_req_t req = '0;
   bit_manip_pkg::bit_result_t result;
   logic load = 1'b0;
   logic [7:0] load_byte = 8'h00;
   logic load_c = 1'b0;
   logic load_z = 1'b0;
   logic [7:0] byte_q;
   logic carry;
   logic zero;
   int fail_count = 0;
   int cmp_count = 0;

   bit_manipulation_unit bit_manipulation_unit_inst (.core_clk(core_clk), .reset_n(reset_n),
      .req(req), .result(result));
   flag_file_model flag_file_model_inst (.core_clk(core_clk), .reset_n(reset_n),
      .result(result), .load(load), .load_byte(load_byte), .load_c(load_c), .load_z(load_z),
      .byte_q(byte_q), .carry(carry), .zero(zero));

   initial
   begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // Returns {write, carry, zero, byte}; op codes follow the package enum
   function automatic logic [10:0] model(input logic [3:0] op, input logic [7:0] b,
      input logic c, input logic z, input logic [2:0] i);
      logic [7:0] m;
      logic [7:0] nb;
      logic nc;
      logic nz;
      m = 8'h01 << i;
      nb = b;
      nc = c;
      nz = z;
      case (op)
         4'h0: nb = b | m;
         4'h1: nb = b & ~m;
         4'h2: nb = b ^ m;
         4'h3: nz = ~b[i];
         4'h4: nc = c & b[i];
         4'h5: nc = c & ~b[i];
         4'h6: nc = c | b[i];
         4'h7: nc = c | ~b[i];
         4'h8: nc = c ^ b[i];
         4'h9: nc = c ^ ~b[i];
         4'hA: nc = b[i];
         4'hB: nc = ~b[i];
         4'hC: nb = c ? (b | m) : (b & ~m);
         4'hD: nb = c ? (b & ~m) : (b | m);
         default: nb = b;
      endcase
      return {op inside {4'h0, 4'h1, 4'h2, 4'hC, 4'hD}, nc, nz, nb};
   endfunction : model

   // Presets the flag file, then issues one request and samples its result
   task automatic do_op(input int op, input logic [7:0] b, input logic c, input logic z,
      input logic [2:0] i, input logic from_reg, output bit_manip_pkg::bit_result_t r);
      @(negedge core_clk);
      load = 1'b1;
      load_byte = b;
      load_c = c;
      load_z = z;
      @(negedge core_clk);
      load = 1'b0;
      req.valid = 1'b1;
      req.op = bit_manip_pkg::bit_op_t'(op);
      req.operand = byte_q;
      req.index_from_reg = from_reg;
      req.imm_index = from_reg ? ~i : i;
      req.index_reg = from_reg ? {5'h15, i} : {5'h0A, ~i};
      req.carry_in = carry;
      req.zero_in = zero;
      repeat (bit_manip_pkg::RESULT_LATENCY) @(negedge core_clk);
      req.valid = 1'b0;
      r = result;
   endtask : do_op

   task automatic run_bit_ops;
      bit_manip_pkg::bit_result_t r;
      logic [7:0] b;
      for (int op = 0; op < 4; op++)
         for (int i = 0; i < 8; i++)
            for (int f = 0; f < 2; f++)
            begin
               b = 8'hA5 ^ {8{f[0]}};
               do_op(op, b, i[0], ~i[0], i[2:0], f[0], r);
               check({r.valid, r.bad_index_source}, 16'h0002);
               check({r.write_operand, r.carry, r.zero, r.operand},
                  model(op[3:0], b, i[0], ~i[0], i[2:0]));
            end
   endtask : run_bit_ops

   task automatic run_carry_ops;
      bit_manip_pkg::bit_result_t r;
      for (int op = 4; op < 12; op++)
         for (int i = 0; i < 8; i++)
            for (int c = 0; c < 2; c++)
            begin
               do_op(op, 8'h3C, c[0], i[1], i[2:0], 1'b0, r);
               check({r.write_operand, r.carry, r.zero, r.operand},
                  model(op[3:0], 8'h3C, c[0], i[1], i[2:0]));
            end
   endtask : run_carry_ops

   task automatic run_store_ops;
      bit_manip_pkg::bit_result_t r;
      logic [10:0] e;
      for (int op = 12; op < 14; op++)
         for (int i = 0; i < 8; i++)
            for (int c = 0; c < 2; c++)
            begin
               e = model(op[3:0], 8'h5A, c[0], 1'b1, i[2:0]);
               do_op(op, 8'h5A, c[0], 1'b1, i[2:0], 1'b0, r);
               check({r.write_operand, r.carry, r.zero, r.operand}, e);
               @(negedge core_clk);
               check(byte_q, e[7:0]);
            end
   endtask : run_store_ops

   // Inverted variants must refuse a register-sourced index
   task automatic run_refused;
      bit_manip_pkg::bit_result_t r;
      for (int op = 5; op < 14; op += 2)
      begin
         do_op(op, 8'hC3, op[1], ~op[1], 3'h2, 1'b1, r);
         check({r.bad_index_source, r.write_operand, r.carry, r.zero, r.operand},
            {1'b1, 1'b0, op[1], ~op[1], 8'hC3});
      end
   endtask : run_refused

   // Codes outside the operation set must pass everything through
   task automatic run_unused;
      bit_manip_pkg::bit_result_t r;
      for (int op = 14; op < 16; op++)
      begin
         do_op(op, 8'h96, 1'b1, 1'b1, 3'h3, 1'b0, r);
         check({r.write_operand, r.carry, r.zero, r.operand},
            model(op[3:0], 8'h96, 1'b1, 1'b1, 3'h3));
      end
   endtask : run_unused

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   // Roughly 700 cycles of traffic are expected
   initial
   begin
      repeat (3000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end

   initial
   begin
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(result), 16'h0000);
      reset_n = 1'b1;
      run_bit_ops();
      run_carry_ops();
      run_store_ops();
      run_refused();
      run_unused();
      end_sim();
   end
endmodule : tb_bit_manipulation_unit
